// ===== include/dmacer_pkg.sv
// Purpose: constants for the per-channel enable and request block
// Assumes: 32-bit classic Wishbone register bus, 32 channels
// Notes: one aligned word per register
package dmacer_pkg;
	localparam int NUM_CH = 32;
	localparam int SW_CH = 30;
	localparam logic [7:0] OFF_ENA_SET = 8'h00;
	localparam logic [7:0] OFF_ENA_CLR = 8'h04;
	localparam logic [7:0] OFF_ENA_STAT = 8'h08;
	localparam logic [7:0] OFF_SW_REQ = 8'h0C;
	localparam logic [7:0] OFF_PERIPH = 8'h10;
	localparam logic [7:0] OFF_MODE_PRI = 8'h14;
	localparam logic [7:0] OFF_MODE_ALT = 8'h18;
	localparam logic [7:0] OFF_MODE_RD = 8'h1C;
	localparam logic [7:0] OFF_SG_SETUP = 8'h20;
	localparam logic [7:0] OFF_SG_BASE = 8'h24;
	localparam logic [7:0] OFF_SG_CNT = 8'h28;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h2C;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h30;
	localparam logic [7:0] OFF_MODE_SEL = 8'h34;
	localparam int MODE_CH_POS = 0;
	localparam int MODE_VAL_POS = 8;
	localparam int MODE_ALT_POS = 16;
	localparam int SG_FLAG_POS = 8;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam int XFER_BEATS = 4;
	typedef enum logic [2:0] {
		xfer_mode_halted,
		xfer_mode_simple,
		xfer_mode_run_to_end,
		xfer_mode_double_buffer,
		xfer_mode_memory_task_list,
		xfer_mode_periph_task_list
	} dmacer_mode_type;
endpackage

// ===== src/dmacer_chan.sv
// Purpose: one channel's enable, mode and transfer sequencer
// Assumes: requests and writes from the same clock domain
// Notes: transfer is a fixed beat count standing in for the datapath
`timescale 1ns/1ps
`default_nettype none
module dmacer_chan
	import dmacer_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic ena_set,
	input wire logic ena_clr,
	input wire logic req,
	input wire logic mode_pri_we,
	input wire logic mode_alt_we,
	input wire logic [2:0] mode_wdata,
	output logic ena,
	output logic [2:0] mode_pri,
	output logic [2:0] mode_alt,
	output logic done
);
	typedef enum logic [1:0] {st_idle, st_run} dmacer_st_type;
	dmacer_st_type st_r;
	logic [2:0] beat_r;
	logic ena_r;
	logic [2:0] pri_r;
	logic [2:0] alt_r;
	logic done_r;
	wire start = ena_r & req & (pri_r != 3'(xfer_mode_halted));
	wire finish = (st_r == st_run) && (beat_r == 3'(XFER_BEATS - 1));
	assign ena = ena_r;
	assign mode_pri = pri_r;
	assign mode_alt = alt_r;
	assign done = done_r;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= st_idle;
			beat_r <= 3'h0;
			done_r <= 1'b0;
		end else begin
			done_r <= finish;
			unique case (st_r)
				st_idle: begin
					beat_r <= 3'h0;
					if (start) begin
						st_r <= st_run;
					end
				end
				st_run: begin
					beat_r <= beat_r + 3'h1;
					if (finish) begin
						st_r <= st_idle;
					end
				end
			endcase
		end
	end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ena_r <= 1'b0;
		end else if (finish | ena_clr) begin
			ena_r <= 1'b0;
		end else if (ena_set) begin
			ena_r <= 1'b1;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pri_r <= 3'h0;
			alt_r <= 3'h0;
		end else begin
			if (finish) begin
				pri_r <= 3'(xfer_mode_halted);
			end else if (mode_pri_we) begin
				pri_r <= mode_wdata;
			end
			if (finish) begin
				alt_r <= 3'(xfer_mode_halted);
			end else if (mode_alt_we) begin
				alt_r <= mode_wdata;
			end
		end
	end
endmodule
`default_nettype wire

// ===== src/dmacer_top.sv
// Purpose: multi-channel enable, request, mode and completion control
// Assumes: classic Wishbone slave, one clock, async active-low reset
// Notes: completion routed to own irq or to peripheral done lines
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module dmacer_top
	import dmacer_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [NUM_CH-1:0] periph_req,
	output logic [NUM_CH-1:0] periph_done,
	output logic [NUM_CH-1:0] chan_ena,
	output logic irq
);
	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic ack_r;
	logic [31:0] dat_r;
	logic [NUM_CH-1:0] req_s1_r;
	logic [NUM_CH-1:0] req_s2_r;
	logic [NUM_CH-1:0] swreq_r;
	logic [NUM_CH-1:0] periph_r;
	logic [NUM_CH-1:0] irq_stat_r;
	logic [NUM_CH-1:0] irq_mask_r;
	logic [NUM_CH-1:0] done_w;
	logic [NUM_CH-1:0] pdone_r;
	logic [4:0] sel_ch_r;
	logic sel_alt_r;
	logic [4:0] sg_ch_r;
	logic sg_flag_r;
	logic [31:0] sg_base_r;
	logic [31:0] sg_cnt_r;
	logic [2:0] mpri_w [NUM_CH];
	logic [2:0] malt_w [NUM_CH];

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// Byte lanes merge the write word with zero for partial writes
	wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [31:0] wdat = wb_dat_i & wmask;
	wire req_in = wb_cyc_i & wb_stb_i & ~ack_r;
	wire wr = req_in & wb_we_i;
	wire wr_set = wr & hit(wb_adr_i, OFF_ENA_SET);
	wire wr_clr = wr & hit(wb_adr_i, OFF_ENA_CLR);
	wire wr_swreq = wr & hit(wb_adr_i, OFF_SW_REQ);
	wire wr_periph = wr & hit(wb_adr_i, OFF_PERIPH);
	wire wr_mpri = wr & hit(wb_adr_i, OFF_MODE_PRI);
	wire wr_malt = wr & hit(wb_adr_i, OFF_MODE_ALT);
	wire wr_sg = wr & hit(wb_adr_i, OFF_SG_SETUP);
	wire wr_sgb = wr & hit(wb_adr_i, OFF_SG_BASE);
	wire wr_sgc = wr & hit(wb_adr_i, OFF_SG_CNT);
	wire wr_istat = wr & hit(wb_adr_i, OFF_IRQ_STAT);
	wire wr_imask = wr & hit(wb_adr_i, OFF_IRQ_MASK);
	wire wr_msel = wr & hit(wb_adr_i, OFF_MODE_SEL);
	wire [4:0] wch = wdat[MODE_CH_POS+:5];
	wire [2:0] wmode = wdat[MODE_VAL_POS+:3];
	// Task list setup writes the mode of the chosen channel
	wire [2:0] sg_mode = wdat[SG_FLAG_POS] ?
		3'(xfer_mode_periph_task_list) :
		3'(xfer_mode_memory_task_list);
	wire [2:0] mode_wdata = wr_sg ? sg_mode : wmode;
	wire [2:0] mode_sel_w = sel_alt_r ? malt_w[sel_ch_r] : mpri_w[sel_ch_r];

	// ------------------------------------------------------------
	// Channels
	// ------------------------------------------------------------
	wire [NUM_CH-1:0] req_any = req_s2_r | swreq_r;
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : gen_ch
			wire sel_g = (wch == 5'(g));
			dmacer_chan u_chan (
				.clk_sys(clk_sys),
				.rst_b(rst_b),
				.ena_set(wr_set & wdat[g]),
				.ena_clr(wr_clr & wdat[g]),
				.req(req_any[g]),
				.mode_pri_we((wr_mpri | (wr_sg & ~wdat[MODE_ALT_POS]))
					& sel_g),
				.mode_alt_we((wr_malt | (wr_sg & wdat[MODE_ALT_POS]))
					& sel_g),
				.mode_wdata(mode_wdata),
				.ena(chan_ena[g]),
				.mode_pri(mpri_w[g]),
				.mode_alt(malt_w[g]),
				.done(done_w[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Completion routing
	// ------------------------------------------------------------
	wire [NUM_CH-1:0] sw_only = ~periph_r;
	wire [NUM_CH-1:0] own_ev = done_w & sw_only;
	wire [NUM_CH-1:0] per_ev = done_w & periph_r;
	wire [NUM_CH-1:0] istat_clr = wr_istat ? wdat : '0;
	wire [NUM_CH-1:0] istat_nxt = (irq_stat_r & ~istat_clr) | own_ev;
	assign irq = |(irq_stat_r & irq_mask_r);
	assign periph_done = pdone_r;

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	logic [31:0] rd_w;
	always_comb begin
		rd_w = RST_ZERO;
		unique case (wb_adr_i)
			OFF_ENA_SET, OFF_ENA_STAT: rd_w = chan_ena;
			OFF_PERIPH: rd_w = periph_r;
			OFF_MODE_RD: rd_w = {29'h0, mode_sel_w};
			OFF_MODE_SEL: rd_w = {15'h0, sel_alt_r, 11'h0, sel_ch_r};
			OFF_SG_SETUP: rd_w = {23'h0, sg_flag_r, 3'h0, sg_ch_r};
			OFF_SG_BASE: rd_w = sg_base_r;
			OFF_SG_CNT: rd_w = sg_cnt_r;
			OFF_IRQ_STAT: rd_w = irq_stat_r;
			OFF_IRQ_MASK: rd_w = irq_mask_r;
			default: rd_w = RST_ZERO;
		endcase
	end
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ack_r <= 1'b0;
			dat_r <= RST_ZERO;
		end else begin
			ack_r <= req_in;
			dat_r <= req_in ? rd_w : RST_ZERO;
		end
	end
	// Peripheral request lines come from other logic, synchronise anyway
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			req_s1_r <= '0;
			req_s2_r <= '0;
		end else begin
			req_s1_r <= periph_req;
			req_s2_r <= req_s1_r;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			swreq_r <= '0;
		end else begin
			swreq_r <= wr_swreq ? wdat : '0;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			periph_r <= RST_ZERO;
			irq_mask_r <= RST_ZERO;
			irq_stat_r <= RST_ZERO;
			pdone_r <= '0;
		end else begin
			if (wr_periph) begin
				periph_r <= wdat;
			end
			if (wr_imask) begin
				irq_mask_r <= wdat;
			end
			irq_stat_r <= istat_nxt;
			pdone_r <= per_ev;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sel_ch_r <= 5'h0;
			sel_alt_r <= 1'b0;
			sg_ch_r <= 5'h0;
			sg_flag_r <= 1'b0;
			sg_base_r <= RST_ZERO;
			sg_cnt_r <= RST_ZERO;
		end else begin
			if (wr_msel) begin
				sel_ch_r <= wch;
				sel_alt_r <= wdat[MODE_ALT_POS];
			end
			if (wr_sg) begin
				sg_ch_r <= wch;
				sg_flag_r <= wdat[SG_FLAG_POS];
			end
			if (wr_sgb) begin
				sg_base_r <= wdat;
			end
			if (wr_sgc) begin
				sg_cnt_r <= wdat;
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/dma_channel_enable_request_bench.sv
// Purpose: self-checking bench for dmacer_top
// Assumes: transfers end within a dozen cycles
// Notes: channels drawn at random, seed fixed
`timescale 1ns/1ps
`default_nettype none
module dma_channel_enable_request_bench
	import dmacer_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, d;
	logic [3:0] wb_sel_i = 4'hF;
	logic wb_ack_o, irq;
	logic [NUM_CH-1:0] periph_req, periph_done, chan_ena, seen = '0, go = '0;
	int bad_count = 0, checks_done = 0, ticks = 0, c;
	dmacer_top u_dut(.clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .periph_req,
		.periph_done, .chan_ena, .irq);
	dmacer_periph u_per(.clk_sys, .rst_b, .go, .periph_done, .periph_req);
	always #5 clk_sys = ~clk_sys;
	task stop_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		seen <= seen | periph_done;
		ticks <= ticks + 1;
		// Generous ceiling, the run needs under three hundred cycles
		if (ticks == 20000) begin
			bad_count++;
			stop_test();
		end
	end
	function logic [31:0] bit_of(int n);
		return 32'h1 << n;
	endfunction
	function logic [31:0] mw(int m, int ch, logic alt);
		return {15'h0, alt, 5'h0, 3'(m), 3'h0, 5'(ch)};
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= v;
		do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_sys);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	initial begin
		c = $urandom(61);
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		chk(chan_ena, '0);
		wb(1'b1, 8'hFC, 32'hFFFF_FFFF);
		rd(8'hFC, 32'h0);
		for (int m = 0; m < 6; m++) begin
			c = $urandom % NUM_CH;
			wb(1'b1, OFF_MODE_ALT, mw(m, c, 1'b0));
			wb(1'b1, OFF_MODE_SEL, mw(0, c, 1'b1));
			rd(OFF_MODE_RD, 32'(m));
		end
		for (int f = 0; f < 2; f++) begin
			wb(1'b1, OFF_SG_SETUP, mw(f, c, 1'b0));
			wb(1'b1, OFF_MODE_SEL, mw(0, c, 1'b0));
			rd(OFF_MODE_RD, f ? 32'h5 : 32'h4);
		end
		rd(OFF_SG_SETUP, mw(1, c, 1'b0));
		rd(OFF_MODE_SEL, mw(0, c, 1'b0));
		d = $urandom;
		wb(1'b1, OFF_SG_BASE, d);
		rd(OFF_SG_BASE, d);
		d = $urandom;
		wb(1'b1, OFF_SG_CNT, d);
		rd(OFF_SG_CNT, d);
		// Software-only channel, completion to irq
		c = $urandom % NUM_CH;
		wb(1'b1, OFF_IRQ_MASK, bit_of(c));
		wb(1'b1, OFF_PERIPH, 32'h0);
		wb(1'b1, OFF_MODE_PRI, mw(1, c, 1'b0));
		wb(1'b1, OFF_MODE_SEL, mw(0, c, 1'b0));
		wb(1'b1, OFF_ENA_SET, bit_of(c));
		rd(OFF_ENA_STAT, bit_of(c));
		rd(OFF_ENA_SET, bit_of(c));
		rd(OFF_MODE_RD, 32'h1);
		wb(1'b1, OFF_SW_REQ, bit_of(c));
		// Set taken on the finishing edge, the completion clear must win
		repeat (XFER_BEATS - 2) @(posedge clk_sys);
		wb(1'b1, OFF_ENA_SET, bit_of(c));
		repeat (10) @(posedge clk_sys);
		rd(OFF_ENA_STAT, 32'h0);
		rd(OFF_MODE_RD, 32'h0);
		wb(1'b1, OFF_MODE_SEL, mw(0, c, 1'b1));
		rd(OFF_MODE_RD, 32'h0);
		chk({31'h0, irq}, 32'h1);
		rd(OFF_IRQ_STAT, bit_of(c));
		wb(1'b1, OFF_IRQ_MASK, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wb(1'b1, OFF_IRQ_STAT, bit_of(c));
		rd(OFF_IRQ_STAT, 32'h0);
		// Mode set but channel still off after completion
		wb(1'b1, OFF_MODE_PRI, mw(1, c, 1'b0));
		wb(1'b1, OFF_SW_REQ, bit_of(c));
		repeat (10) @(posedge clk_sys);
		rd(OFF_IRQ_STAT, 32'h0);
		wb(1'b1, OFF_ENA_SET, bit_of(c));
		chk(chan_ena, bit_of(c));
		wb(1'b1, OFF_SW_REQ, bit_of(c));
		repeat (10) @(posedge clk_sys);
		rd(OFF_IRQ_STAT, bit_of(c));
		wb(1'b1, OFF_IRQ_STAT, bit_of(c));
		// Peripheral channel, request before enable
		c = $urandom % NUM_CH;
		wb(1'b1, OFF_PERIPH, bit_of(c));
		wb(1'b1, OFF_MODE_PRI, mw(2, c, 1'b0));
		go <= bit_of(c);
		@(posedge clk_sys);
		go <= '0;
		repeat (12) @(posedge clk_sys);
		chk(seen, '0);
		wb(1'b1, OFF_ENA_SET, bit_of(c));
		repeat (12) @(posedge clk_sys);
		chk(seen, bit_of(c));
		rd(OFF_IRQ_STAT, 32'h0);
		rd(OFF_ENA_STAT, 32'h0);
		stop_test();
	end
endmodule
`default_nettype wire

// ===== tb/dmacer_monitor.sv
// Purpose: bus and completion checks on the top ports
// Assumes: one clock, master keeps one request open
// Notes: bound to dmacer_top
`timescale 1ns/1ps
`default_nettype none
module dmacer_monitor
	import dmacer_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [NUM_CH-1:0] periph_done,
	input wire logic [NUM_CH-1:0] chan_ena,
	input wire logic irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("ack late");
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == '0)
		else $error("data off ack");
	AST_DONE_CLR: assert property (|periph_done |->
		(periph_done & ~($past(chan_ena, 2) & ~$past(chan_ena))) == '0)
		else $error("done without auto clear");
	AST_DONE_ONE: assert property ((periph_done & $past(periph_done)) == '0)
		else $error("done too long");
	AST_DONE_ENA: assert property ((periph_done & ~$past(chan_ena, 4)) == '0)
		else $error("done on idle channel");
	AST_IRQ_FALL: assert property ($fell(irq) |-> wb_ack_o && wb_we_i)
		else $error("irq fell alone");
	AST_ENA_RISE: assert property (|(chan_ena & ~$past(chan_ena))
		|-> wb_ack_o && wb_we_i) else $error("enable rose alone");
endmodule
bind dmacer_top dmacer_monitor u_mon(.clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_dat_o, .wb_ack_o, .periph_done, .chan_ena, .irq);
`default_nettype wire

// ===== tb/dmacer_periph.sv
// Purpose: peripheral side raising request levels
// Assumes: done pulses on the same clock
// Notes: a request holds until served, as a real one would
`timescale 1ns/1ps
`default_nettype none
module dmacer_periph
	import dmacer_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [NUM_CH-1:0] go,
	input wire logic [NUM_CH-1:0] periph_done,
	output logic [NUM_CH-1:0] periph_req
);
	// Dropped only on done, so a late enable still sees it
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			periph_req <= '0;
		else
			periph_req <= (periph_req | go) & ~periph_done;
	end
endmodule
`default_nettype wire
